// *** hw/epg_top.sv ***
/*
 * Eight-channel pulse width modulator with its register port and
 * the output stage of 32 general pins.
 * Assumes one 40 MHz clock, synchronous pin inputs and a master
 * that issues one-cycle strobes and never waits.
 */
`timescale 1ns/1ps
`default_nettype none
`include "epg_defines.svh"

module epg_top (
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire epg_pkg::epg_addr_t addr_i,
	input  wire epg_pkg::epg_word_t wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output var  epg_pkg::epg_word_t rdata_o,
	input  wire epg_pkg::epg_pins_t pin_i,
	output var  epg_pkg::epg_pins_t pin_o,
	output var  epg_pkg::epg_pins_t pin_oe_n_o,
	output var  epg_pkg::epg_pins_t pullup_o
);
	import epg_pkg::*;

	epg_tick_t tick_r;
	epg_duty_t limit_r;
	epg_pins_t dir_r;
	epg_pins_t outv_r;
	epg_duty_t duty_r [`EPG_CHANS];
	epg_word_t rdata_r;

	logic [`EPG_US_CNT_W-1:0] us_cnt_r;
	epg_tick_t                tk_cnt_r;
	epg_duty_t                cnt_r;
	logic [`EPG_CHANS-1:0]    pwm_r;
	epg_pins_t                pin_r;
	epg_pins_t                oe_n_r;
	epg_pins_t                pu_r;

	// Address decode
	wire wr_en   = ce_i && wr_i;
	wire rd_en   = ce_i && rd_i;
	wire hit_tk  = addr_i == `EPG_OFS_TICK;
	wire hit_lim = addr_i == `EPG_OFS_LIMIT;
	wire hit_dir = addr_i == `EPG_OFS_DIR;
	wire hit_out = addr_i == `EPG_OFS_OUTV;
	wire hit_st  = addr_i == `EPG_OFS_STATUS;
	wire hit_pin = addr_i == `EPG_OFS_PINS;
	wire hit_dty = addr_i[7:5] == `EPG_DUTY_TAG;
	wire [`EPG_CH_W-1:0] dty_sel = addr_i[4:2];
	// Declared here because status readback needs it before the prescaler
	wire lim_on  = limit_r != 8'h00;

	// Register writes
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_r  <= `EPG_RST_TICK;
			limit_r <= `EPG_RST_LIMIT;
			dir_r   <= `EPG_RST_DIR;
			outv_r  <= `EPG_RST_OUTV;
		end else if (wr_en) begin
			if (hit_tk)
				tick_r <= wdata_i[`EPG_TICK_W-1:0];
			if (hit_lim)
				limit_r <= wdata_i[7:0];
			if (hit_dir)
				dir_r <= wdata_i;
			if (hit_out)
				outv_r <= wdata_i;
		end
	end

	// Per-channel duty registers
	genvar gd;
	generate
		for (gd = 0; gd < `EPG_CHANS; gd++) begin : g_duty
			wire dty_we = wr_en && hit_dty && dty_sel == `EPG_CH_W'(gd);
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i)
					duty_r[gd] <= `EPG_RST_DUTY;
				else if (dty_we)
					duty_r[gd] <= wdata_i[7:0];
			end
		end
	endgenerate

	a_duty_write: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		wr_en && hit_dty
		|=> duty_r[$past(dty_sel)] == $past(wdata_i[7:0]))
		else $error("duty write not stored");

	// Readback
	wire [`EPG_DATA_W-1:0] st_word =
		{23'h0, lim_on, cnt_r};
	wire [`EPG_DATA_W-1:0] rd_mux =
		hit_tk  ? {17'h0, tick_r} :
		hit_lim ? {24'h0, limit_r} :
		hit_dir ? dir_r :
		hit_out ? outv_r :
		hit_st  ? st_word :
		hit_pin ? pin_i :
		hit_dty ? {24'h0, duty_r[dty_sel]} :
		32'h0000_0000;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rdata_r <= 32'h0000_0000;
		else if (ce_i)
			rdata_r <= rd_en ? rd_mux : 32'h0000_0000;
	end
	assign rdata_o = rdata_r;

	// Tick prescaler: microsecond strobe, then tick_period_micros of them.
	// Out-of-range periods are clamped, so a bad write cannot stall the tick.
	wire [`EPG_US_CNT_W-1:0] us_last =
		`EPG_US_CNT_W'(`EPG_US_CYC - 1);
	wire us_p = us_cnt_r == us_last;
	wire epg_tick_t tk_eff =
		(tick_r < `EPG_TICK_MIN_US) ? `EPG_TICK_MIN_US :
		(tick_r > `EPG_TICK_MAX_US) ? `EPG_TICK_MAX_US : tick_r;
	// At-or-above compare: lowering the period mid-count cannot overrun
	wire tick_p = us_p && tk_cnt_r >= tk_eff - 15'h0001;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			us_cnt_r <= '0;
			tk_cnt_r <= '0;
		end else if (ce_i) begin
			if (!lim_on || us_p)
				us_cnt_r <= '0;
			else
				us_cnt_r <= us_cnt_r + 6'h01;
			if (!lim_on || tick_p)
				tk_cnt_r <= '0;
			else if (us_p)
				tk_cnt_r <= tk_cnt_r + 15'h0001;
		end
	end

	// Shared counter; also wraps if the limit was lowered below it
	wire epg_duty_t lim_m1  = limit_r - 8'h01;
	wire epg_duty_t cnt_nxt =
		(cnt_r >= lim_m1) ? 8'h00 : cnt_r + 8'h01;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			cnt_r <= 8'h00;
		else if (ce_i) begin
			if (!lim_on)
				cnt_r <= 8'h00;
			else if (tick_p)
				cnt_r <= cnt_nxt;
		end
	end

	// Comparators, one per channel
	genvar gc;
	generate
		for (gc = 0; gc < `EPG_CHANS; gc++) begin : g_cmp
			wire full = duty_r[gc] >= limit_r;
			wire below = cnt_r < duty_r[gc];
			wire pwm_nxt = lim_on && (full || below);
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i)
					pwm_r[gc] <= 1'b0;
				else if (ce_i)
					pwm_r[gc] <= pwm_nxt;
			end

			a_duty_zero_low: assert property (
				@(posedge clock_i) disable iff (!rst_n_i)
				ce_i && duty_r[gc] == 8'h00 |=> !pwm_r[gc])
				else $error("zero duty channel not low");

			a_duty_full_high: assert property (
				@(posedge clock_i) disable iff (!rst_n_i)
				ce_i && lim_on && duty_r[gc] >= limit_r
				|=> pwm_r[gc])
				else $error("full duty channel not high");

			a_duty_compare: assert property (
				@(posedge clock_i) disable iff (!rst_n_i)
				ce_i && lim_on && duty_r[gc] < limit_r
				|=> pwm_r[gc] == ($past(cnt_r) < $past(duty_r[gc])))
				else $error("channel level disagrees with counter");
		end
	endgenerate

	// Pin stage: pins 24..31 take channel levels while running,
	// the rest always follow the output value register.
	genvar gp;
	generate
		for (gp = 0; gp < `EPG_PINS; gp++) begin : g_pin
			wire val;
			if (gp >= `EPG_PIN_BASE) begin : g_pwm
				assign val = lim_on ? pwm_r[gp - `EPG_PIN_BASE] : outv_r[gp];
			end else begin : g_gpo
				assign val = outv_r[gp];
			end
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					pin_r[gp]  <= 1'b0;
					oe_n_r[gp] <= 1'b1;
					pu_r[gp]   <= 1'b0;
				end else if (ce_i) begin
					pin_r[gp]  <= dir_r[gp] & val;
					oe_n_r[gp] <= ~dir_r[gp];
					pu_r[gp]   <= ~dir_r[gp] & val;
				end
			end

			a_dir_enable: assert property (
				@(posedge clock_i) disable iff (!rst_n_i)
				ce_i |=> pin_oe_n_o[gp] == !$past(dir_r[gp]))
				else $error("pin enable does not follow direction");
		end
	endgenerate

	assign pin_o      = pin_r;
	assign pin_oe_n_o = oe_n_r;
	assign pullup_o   = pu_r;

	a_off_quiet: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && !lim_on |=> pwm_r == 8'h00 && cnt_r == 8'h00)
		else $error("modulator active with zero limit");

	a_cnt_wrap: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && lim_on && tick_p && cnt_r == lim_m1
		|=> cnt_r == 8'h00)
		else $error("counter missed its wrap");

	a_cnt_step: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && lim_on && tick_p && cnt_r < lim_m1
		|=> cnt_r == $past(cnt_r) + 8'h01)
		else $error("counter did not advance on tick");

	a_cnt_hold: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		lim_on && !tick_p && $stable(limit_r) |=> $stable(cnt_r))
		else $error("counter moved between ticks");

	a_pin_drive: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && lim_on && dir_r[`EPG_PIN_BASE]
		|=> pin_o[`EPG_PIN_BASE] == $past(pwm_r[0])
		&& !pin_oe_n_o[`EPG_PIN_BASE])
		else $error("output pin not driven by channel 0");

	a_pin_pullup: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && lim_on && !dir_r[`EPG_PINS-1]
		|=> pullup_o[`EPG_PINS-1] == $past(pwm_r[`EPG_CHANS-1])
		&& !pin_o[`EPG_PINS-1])
		else $error("input pin pull-up not switched by channel 7");

	a_us_strobe: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && lim_on && us_p |=> us_cnt_r == 6'h00 ##1
		($past(!ce_i || !lim_on) || us_cnt_r == 6'h01))
		else $error("microsecond prescaler misbehaves");

	a_read_data: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && rd_i && hit_lim |=> rdata_o == {24'h0, $past(limit_r)})
		else $error("limit readback wrong");

	a_status_read: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		rd_en && hit_st
		|=> rdata_o == {23'h0, $past(lim_on), $past(cnt_r)})
		else $error("status readback wrong");

	a_ce_freeze: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		!ce_i |=> $stable(cnt_r) && $stable(pin_o) && $stable(rdata_o))
		else $error("state moved with clock enable low");

endmodule

`default_nettype wire

// *** include/epg_defines.svh ***
/*
 * Register offsets, field widths, reset values and timing counts
 * for the eight-channel pulse width modulator.
 * Assumes a byte-addressed word bus with an 8-bit address.
 */
`ifndef EPG_DEFINES_SVH
`define EPG_DEFINES_SVH

`define EPG_ADDR_W       8
`define EPG_DATA_W       32
`define EPG_PINS         32
`define EPG_CHANS        8
`define EPG_CH_W         3
`define EPG_PIN_BASE     24

`define EPG_OFS_TICK     8'h00
`define EPG_OFS_LIMIT    8'h04
`define EPG_OFS_DIR      8'h08
`define EPG_OFS_OUTV     8'h0C
`define EPG_OFS_STATUS   8'h10
`define EPG_OFS_PINS     8'h14
`define EPG_DUTY_TAG     3'h1
`define EPG_ST_RUN_BIT   8

`define EPG_TICK_W       15
`define EPG_TICK_MIN_US  15'h0014
`define EPG_TICK_MAX_US  15'h4000
`define EPG_RST_TICK     15'h0014
`define EPG_RST_LIMIT    8'h00
`define EPG_RST_DUTY     8'h00
`define EPG_RST_DIR      32'h0000_0000
`define EPG_RST_OUTV     32'h0000_0000

`define EPG_CLK_NS       25
`define EPG_US_NS        1000
`define EPG_US_CYC       (`EPG_US_NS / `EPG_CLK_NS)
`define EPG_US_CNT_W     6

`endif

// *** include/epg_pkg.sv ***
/*
 * Types shared by the pulse width modulator design files.
 * Assumes epg_defines.svh is on the include path.
 */
`include "epg_defines.svh"

package epg_pkg;
	typedef logic [`EPG_ADDR_W-1:0] epg_addr_t;
	typedef logic [`EPG_DATA_W-1:0] epg_word_t;
	typedef logic [`EPG_PINS-1:0]   epg_pins_t;
	typedef logic [7:0]             epg_duty_t;
	typedef logic [`EPG_TICK_W-1:0] epg_tick_t;
endpackage

// *** testbench/test_eight_channel_pwm_generator.sv ***
/* Self-checking bench for the eight-channel pulse width modulator.
   Assumes epg_top, epg_pkg and epg_defines.svh are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "epg_defines.svh"

module test_eight_channel_pwm_generator;
	import epg_pkg::*;
	logic        clock_i, rst_n_i, ce_i, wr_i, rd_i;
	epg_addr_t   addr_i;
	epg_word_t   wdata_i, rdata_o, dir, outv;
	epg_pins_t   pin_i, pin_o, pin_oe_n_o, pullup_o;
	int          bad_count = 0, check_count = 0, cyc = 0, tick;
	logic [31:0] seed = 32'h5DE4;
	epg_duty_t   duty [8];
	int          hi [8];

	epg_top u_epg_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pullup_o(pullup_o));

	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	// Whole run needs about 22300 cycles
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count = bad_count + 1;
			summarize();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic int exp_high(epg_duty_t d, int lim, int t);
		return ((int'(d) >= lim) ? lim : int'(d)) * t * `EPG_US_CYC;
	endfunction

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input epg_word_t got, input epg_word_t exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input epg_addr_t a, input epg_word_t d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input epg_addr_t a, input epg_word_t exp);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask

	task automatic chk_pins();
		chk(pin_o, outv & dir);
		chk(pin_oe_n_o, ~dir);
		chk(pullup_o, outv & ~dir);
	endtask

	initial begin
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = '0;
		wdata_i = '0;
		pin_i = '0;
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		rd(`EPG_OFS_TICK, 32'h14);
		rd(`EPG_OFS_LIMIT, 32'h0);
		rd(`EPG_OFS_DIR, 32'h0);
		rd(`EPG_OFS_OUTV, 32'h0);
		for (int n = 0; n < 8; n++) begin
			rd(epg_addr_t'(8'h20 + 4 * n), 32'h0);
		end
		rd(8'h40, 32'h0);
		$display("test reset done");
		// Modulator off: every pin follows the plain output registers
		for (int i = 0; i < 4; i++) begin
			dir = rnd();
			outv = rnd();
			wr(`EPG_OFS_DIR, dir);
			pin_i <= rnd();
			wr(`EPG_OFS_OUTV, outv);
			wr(8'h40, rnd());
			rd(`EPG_OFS_DIR, dir);
			rd(`EPG_OFS_OUTV, outv);
			rd(`EPG_OFS_PINS, pin_i);
			rd(`EPG_OFS_STATUS, 32'h0);
			repeat (3) @(posedge clock_i);
			#1 chk_pins();
		end
		$display("test static pins done");
		// Clock enable low: the write below must be lost
		@(posedge clock_i);
		ce_i <= 1'b0;
		wr(`EPG_OFS_DIR, ~dir);
		repeat (2) @(posedge clock_i);
		#1 chk_pins();
		@(posedge clock_i);
		ce_i <= 1'b1;
		rd(`EPG_OFS_DIR, dir);
		$display("test clock enable done");
		for (int lim = 2; lim <= 4; lim++) begin
			tick = (lim == 4) ? 21 : 20;
			dir = rnd();
			outv = rnd();
			wr(`EPG_OFS_DIR, dir);
			wr(`EPG_OFS_OUTV, outv);
			wr(`EPG_OFS_TICK, 32'(tick));
			for (int n = 0; n < 8; n++) begin
				duty[n] = (n == 0) ? 8'h00 : (n == 7) ? 8'hFF : 8'(rnd() % 6);
				wr(epg_addr_t'(8'h20 + 4 * n), 32'(duty[n]));
				hi[n] = 0;
			end
			wr(`EPG_OFS_LIMIT, 32'(lim));
			rd(`EPG_OFS_LIMIT, 32'(lim));
			repeat (lim * tick * 80 + 10) @(posedge clock_i);
			// Any window of exactly one period holds the full high time
			repeat (lim * tick * `EPG_US_CYC) begin
				@(posedge clock_i);
				#1;
				for (int n = 0; n < 8; n++) begin
					hi[n] += dir[24 + n] ? int'(pin_o[24 + n]) : int'(pullup_o[24 + n]);
				end
				chk({pin_o[31:24] & ~dir[31:24], pullup_o[31:24] & dir[31:24]}, 32'h0);
			end
			for (int n = 0; n < 8; n++) begin
				chk(32'(hi[n]), 32'(exp_high(duty[n], lim, tick)));
			end
			wr(`EPG_OFS_LIMIT, 32'h0);
			repeat (4) @(posedge clock_i);
			#1 chk_pins();
			rd(`EPG_OFS_STATUS, 32'h0);
			$display("test limit %0d done", lim);
		end
		summarize();
	end
endmodule
`default_nettype wire
